// ===== spc0_pkg.sv
package spc0_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] CTRL0_ADDR   = 12'h000;
  localparam logic [11:0] STATUS_ADDR  = 12'h004;
  localparam logic [31:0] CTRL0_RESET  = 32'h00000000;
  localparam logic [31:0] STATUS_RESET = 32'h00000000;

  // ----------------------------------------------------------------
  // Control register 0 field positions
  // ----------------------------------------------------------------
  localparam int WAKE_HI_POS    = 28;
  localparam int BLOCK_IE_POS   = 27;
  localparam int RXTO_IE_POS    = 26;
  localparam int LEAD_LSB       = 21;
  localparam int LAG_LSB        = 16;
  localparam int SAMPLE_POS     = 15;
  localparam int MATCH_IE_POS   = 14;
  localparam int MUTE_POS       = 13;
  localparam int WORD_POS       = 12;
  localparam int WAKE_LO_POS    = 11;
  localparam int PARITY_POS     = 10;
  localparam int PODD_POS       = 9;
  localparam int PARITY_ERROR_FLAG_IE_POS    = 8;
  localparam int TXE_IE_POS     = 7;
  localparam int TXD_IE_POS     = 6;
  localparam int RXR_IE_POS     = 5;
  localparam int IDLE_IE_POS    = 4;
  localparam int TX_ON_POS      = 3;
  localparam int RX_ON_POS      = 2;
  localparam int SLEEP_POS      = 1;
  localparam int PORT_ON_POS    = 0;

  // Writable bits, and those frozen while the port is on
  localparam logic [31:0] CTRL0_RW_MASK  = 32'h1FFFFFFF;
  localparam logic [31:0] CTRL0_LOCKMASK = 32'h13FF9E00;

  // ----------------------------------------------------------------
  // Wakeup method encodings and sample counts
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SPC0_WAKE_IDLE  = 2'h0,
    SPC0_WAKE_ADDR  = 2'h1,
    SPC0_WAKE_DATA  = 2'h2
  } spc0_wake_t;

  localparam logic [4:0] SAMPLES_X16 = 5'h10;
  localparam logic [4:0] SAMPLES_X8  = 5'h08;
  localparam logic [3:0] BITS_EIGHT  = 4'h8;
  localparam logic [3:0] BITS_NINE   = 4'h9;

endpackage

// ===== spc0_ctrl0.sv
// The APB register port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none

module spc0_ctrl0
(
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        parity_error_flag,
  input  wire logic        tx_empty_flag,
  input  wire logic        tx_done_flag,
  input  wire logic        rx_ready_flag,
  input  wire logic        overrun_flag,
  input  wire logic        idle_line_flag,
  input  wire logic        char_match_flag,
  input  wire logic        rx_timeout_flag,
  input  wire logic        block_end_flag,
  output logic             irqReq,
  output logic             transmitterOn,
  output logic             receiverOn,
  output logic             prescalerRun,
  output logic             outputsOn,
  output logic             sleepWakeAllow,
  output logic             muteModeOn,
  output logic [1:0]       wakeMethod,
  output logic [4:0]       driverLeadDelay,
  output logic [4:0]       driverLagDelay,
  output logic [4:0]       samplesPerBit,
  output logic [3:0]       dataBits,
  output logic             parityOn,
  output logic             parityOddSelect
);

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic [31:0] ctrl0;
  logic [31:0] next_ctrl0;
  logic [31:0] strbMask;
  logic        wrAccess;
  logic        rdAccess;
  logic        hitCtrl;
  logic        hitStatus;
  logic [8:0]  flagsSync1;
  logic [8:0]  flagsSync2;
  logic        portOn;

  // Zero wait state: every access completes at its first access cycle
  assign wrAccess  = psel && penable && pwrite;
  assign rdAccess  = psel && penable && !pwrite;
  assign hitCtrl   = (paddr == spc0_pkg::CTRL0_ADDR);
  assign hitStatus = (paddr == spc0_pkg::STATUS_ADDR);
  assign portOn    = ctrl0[spc0_pkg::PORT_ON_POS];

  // Byte strobes widened to a bit mask
  always_comb
  begin
    strbMask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
  end

  // ----------------------------------------------------------------
  // Control register write
  // ----------------------------------------------------------------
  // Locked bits keep their value while the port is on
  always_comb
  begin
    logic [31:0] allowMask;
    allowMask = strbMask & spc0_pkg::CTRL0_RW_MASK;
    if (portOn)
    begin
      allowMask = allowMask & ~spc0_pkg::CTRL0_LOCKMASK;
    end
    next_ctrl0 = (ctrl0 & ~allowMask) | (pwdata & allowMask);
  end

  // Register update on the access phase
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      ctrl0 <= spc0_pkg::CTRL0_RESET;
    end
    else if (wrAccess && hitCtrl)
    begin
      ctrl0 <= next_ctrl0;
    end
  end

  // ----------------------------------------------------------------
  // Flag synchronisers (flags may come from the link side)
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      flagsSync1 <= 9'h000;
      flagsSync2 <= 9'h000;
    end
    else
    begin
      flagsSync1 <= {block_end_flag, rx_timeout_flag, char_match_flag,
                     idle_line_flag, overrun_flag, rx_ready_flag,
                     tx_done_flag, tx_empty_flag, parity_error_flag};
      flagsSync2 <= flagsSync1;
    end
  end

  // ----------------------------------------------------------------
  // Bus answer
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !(hitCtrl || hitStatus);
      if (psel && !penable && !pwrite && hitCtrl)
      begin
        prdata <= ctrl0;
      end
      else if (psel && !penable && !pwrite && hitStatus)
      begin
        prdata <= {23'h000000, flagsSync2};
      end
      else
      begin
        prdata <= 32'h00000000;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt merge
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      irqReq <= 1'b0;
    end
    else
    begin
      irqReq <=
        (flagsSync2[0] & ctrl0[spc0_pkg::PARITY_ERROR_FLAG_IE_POS])  |
        (flagsSync2[1] & ctrl0[spc0_pkg::TXE_IE_POS])   |
        (flagsSync2[2] & ctrl0[spc0_pkg::TXD_IE_POS])   |
        ((flagsSync2[3] | flagsSync2[4])
          & ctrl0[spc0_pkg::RXR_IE_POS])                |
        (flagsSync2[5] & ctrl0[spc0_pkg::IDLE_IE_POS])  |
        (flagsSync2[6] & ctrl0[spc0_pkg::MATCH_IE_POS]) |
        (flagsSync2[7] & ctrl0[spc0_pkg::RXTO_IE_POS])  |
        (flagsSync2[8] & ctrl0[spc0_pkg::BLOCK_IE_POS]);
    end
  end

  // ----------------------------------------------------------------
  // Decoded controls toward the data path
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      transmitterOn   <= 1'b0;
      receiverOn      <= 1'b0;
      prescalerRun    <= 1'b0;
      outputsOn       <= 1'b0;
      sleepWakeAllow  <= 1'b0;
      muteModeOn      <= 1'b0;
      wakeMethod      <= spc0_pkg::SPC0_WAKE_IDLE;
      driverLeadDelay <= 5'h00;
      driverLagDelay  <= 5'h00;
      samplesPerBit   <= spc0_pkg::SAMPLES_X16;
      dataBits        <= spc0_pkg::BITS_EIGHT;
      parityOn        <= 1'b0;
      parityOddSelect <= 1'b0;
    end
    else
    begin
      transmitterOn   <= portOn && ctrl0[spc0_pkg::TX_ON_POS];
      receiverOn      <= portOn && ctrl0[spc0_pkg::RX_ON_POS];
      prescalerRun    <= portOn;
      outputsOn       <= portOn;
      sleepWakeAllow  <= ctrl0[spc0_pkg::SLEEP_POS];
      muteModeOn      <= ctrl0[spc0_pkg::MUTE_POS];
      if (ctrl0[spc0_pkg::WAKE_HI_POS])
      begin
        wakeMethod <= spc0_pkg::SPC0_WAKE_DATA;
      end
      else if (ctrl0[spc0_pkg::WAKE_LO_POS])
      begin
        wakeMethod <= spc0_pkg::SPC0_WAKE_ADDR;
      end
      else
      begin
        wakeMethod <= spc0_pkg::SPC0_WAKE_IDLE;
      end
      driverLeadDelay <= ctrl0[spc0_pkg::LEAD_LSB +: 5];
      driverLagDelay  <= ctrl0[spc0_pkg::LAG_LSB +: 5];
      samplesPerBit   <= ctrl0[spc0_pkg::SAMPLE_POS] ?
                         spc0_pkg::SAMPLES_X8 : spc0_pkg::SAMPLES_X16;
      dataBits        <= ctrl0[spc0_pkg::WORD_POS] ?
                         spc0_pkg::BITS_NINE : spc0_pkg::BITS_EIGHT;
      parityOn        <= ctrl0[spc0_pkg::PARITY_POS];
      parityOddSelect <= ctrl0[spc0_pkg::PODD_POS];
    end
  end

endmodule

`default_nettype wire

// ===== spc0_checker.sv
`timescale 1ns/10ps
`default_nettype none
module spc0_checker
(
  input wire logic        core_clk,
  input wire logic        rst_b,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        transmitterOn,
  input wire logic        receiverOn,
  input wire logic        prescalerRun,
  input wire logic        outputsOn,
  input wire logic        sleepWakeAllow,
  input wire logic        muteModeOn,
  input wire logic [1:0]  wakeMethod,
  input wire logic [4:0]  driverLeadDelay,
  input wire logic [4:0]  samplesPerBit,
  input wire logic [3:0]  dataBits
);
  // ----------------------------------------
  // Control word properties
  // ----------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  // Accepted write of the control word
  sequence wrCtrl;
    psel && penable && pready && pwrite && paddr == 12'h000;
  endsequence

  wake_code_a:
    assert property (wakeMethod != 2'h3) else $error("bad wake code");
  lock_hold_a:
    assert property ($past(prescalerRun) |-> $stable({driverLeadDelay,
      samplesPerBit, dataBits, wakeMethod})) else $error("locked moved");
  tx_gate_a:
    assert property (transmitterOn |-> prescalerRun) else $error("tx on");
  rx_gate_a:
    assert property (receiverOn |-> prescalerRun) else $error("rx on");
  port_pair_a:
    assert property (outputsOn == prescalerRun) else $error("port split");
  sample_rate_a:
    assert property (samplesPerBit inside {5'h10, 5'h08})
      else $error("bad sample count");
  word_len_a:
    assert property (dataBits inside {4'h8, 4'h9}) else $error("bad bits");
  free_write_a:
    assert property (wrCtrl |=> ##1 muteModeOn == $past(pwdata[13], 2)
      && sleepWakeAllow == $past(pwdata[1], 2)) else $error("no update");
  tx_write_a:
    assert property (wrCtrl |=> ##1 transmitterOn ==
      ($past(pwdata[3], 2) && $past(pwdata[0], 2))) else $error("tx bad");
endmodule
`default_nettype wire

// ===== spc0_flag_src.sv
`timescale 1ns/10ps
`default_nettype none
module spc0_flag_src
(
  input  wire logic       core_clk,
  input  wire logic [8:0] raise,
  output logic      [8:0] flags
);
  // Status events from the line side, one edge late
  always_ff @(posedge core_clk)
    flags <= raise;
endmodule
`default_nettype wire

// ===== tb_serial_port_control_reg0.sv
`timescale 1ns/10ps
`default_nettype none
module tb_serial_port_control_reg0;
  logic        core_clk, rst_b, psel, penable, pwrite, pready, pslverr;
  logic        irqReq, transmitterOn, receiverOn, prescalerRun, outputsOn;
  logic        sleepWakeAllow, muteModeOn, parityOn, parityOddSelect, err;
  logic        parity_error_flag, tx_empty_flag, tx_done_flag;
  logic        rx_ready_flag, overrun_flag, idle_line_flag;
  logic        char_match_flag, rx_timeout_flag, block_end_flag;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb, dataBits;
  logic [8:0]  raise, fl, mask;
  logic [1:0]  wakeMethod;
  logic [4:0]  driverLeadDelay, driverLagDelay, samplesPerBit;
  int          failures, checks_done, cyc;
  int          ieBit [9] = '{8, 7, 6, 5, 5, 4, 14, 26, 27};

  assign {block_end_flag, rx_timeout_flag, char_match_flag, idle_line_flag,
    overrun_flag, rx_ready_flag, tx_done_flag, tx_empty_flag,
    parity_error_flag} = fl;
  spc0_ctrl0 u_spc0_ctrl0 (.*);
  spc0_flag_src u_spc0_flag_src (.core_clk(core_clk), .raise(raise),
    .flags(fl));

  // ----------------------------------------
  // Clock, timeout, helpers
  // ----------------------------------------
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      failures++;
      conclude();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // One APB transfer, held until pready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1)
      @(posedge core_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask

  // Control write, then let decoded outputs land
  task wr(input logic [31:0] d);
    apb(1'b1, 12'h000, d);
    @(posedge core_clk);
  endtask

  task conclude();
    $display("failures=%0d checks_done=%0d", failures, checks_done);
    if (failures == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    {core_clk, rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
    {raise, failures, checks_done, cyc} = '0;
    pstrb = 4'hF;
    repeat (4) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h0);
    chk({samplesPerBit, dataBits}, {5'h10, 4'h8});
    for (int i = 0; i < 4; i++)
    begin
      wr({3'h0, i[1], 16'h0, i[0], 11'h0});
      chk(wakeMethod, i[1] ? 2'h2 : {1'b0, i[0]});
    end
    wr(32'hFFFFFFFE);
    chk({driverLeadDelay, driverLagDelay}, 10'h3FF);
    chk({samplesPerBit, dataBits}, {5'h08, 4'h9});
    chk({parityOn, parityOddSelect, muteModeOn}, 3'h7);
    chk({sleepWakeAllow, prescalerRun}, 2'h2);
    chk({transmitterOn, receiverOn}, 2'h0);
    wr(32'hFFFFFFFF);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h1FFFFFFF);
    wr(32'h0000000D);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h13FF9E0D);
    chk({transmitterOn, receiverOn}, 2'h3);
    chk({outputsOn, muteModeOn}, 2'h2);
    wr(32'h0);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h13FF9E00);
    wr(32'h0);
    apb(1'b0, 12'h008, 32'h0);
    chk({err, rd}, {1'b1, 32'h0});
    for (int i = 0; i < 9; i++)
    begin
      mask = (i == 3 || i == 4) ? 9'h018 : 9'h001 << i;
      wr(32'h1 << ieBit[i]);
      raise <= 9'h001 << i;
      repeat (6) @(posedge core_clk);
      chk(irqReq, 1'b1);
      chk(irqReq, 1'b1);
      raise <= ~mask;
      repeat (6) @(posedge core_clk);
      chk(irqReq, 1'b0);
      chk(irqReq, 1'b0);
    end
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, {23'h0, ~mask});
    conclude();
  end
endmodule

bind spc0_ctrl0 spc0_checker u_spc0_checker (.*);
`default_nettype wire
